// ==== plr_pkg.sv ====
// Constants, field layout and types for the timing loop run-time registers
// How it works
// - The loop bandwidth in hertz is one divided by the programmed bandwidth index.
// - A 16-bit phase error threshold in ns judges leaky-bucket error events in all locking states.
// - A 16-bit bucket capacity bounds the accumulated count of phase error events.
// - Tracking resumes from signal loss or holdover only when phase error is within re-entry tolerance.
// - The loss-of-lock alarm rises when phase error exceeds the 16-bit hard tolerance in ns.
// - Config bit 0 aligns synth x and bit 1 aligns synth y to the pulse reference.
// - Config bits 3:2 pick the bandwidth shift rate: 0 normal, 1 slower, 2 slowest, 3 faster.
// - Aligned output frequency is n times 8 kHz from bits 16:0; software keeps bits 47:17 zero.
// - A zero aligned output frequency means the pulse output needs no phase alignment.
// - Build-out compensation speed is at most index times 16 to the band times 10 ps per second.
// - The signed detector offset in 10 ps units is added to every reference phase reading.
// - A 28-bit signed master clock correction of 0.851495 ppt per unit sits in a 48-bit field.
// - Loop parameter bits 5:0 give the fast bandwidth index and bits 7:6 the damping selection.
// - Run-time control value 1 forces manual holdover and value 0 means normal operation.
package plr_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NUM_FIELDS = 12;
  localparam int FLD_RUNTIME_CONTROL = 0;
  localparam int FLD_LOOP_PARAM = 1;
  localparam int FLD_TARGET_BW = 2;
  localparam int FLD_BUCKET_THR = 3;
  localparam int FLD_BUCKET_CAP = 4;
  localparam int FLD_REENTRY_TOL = 5;
  localparam int FLD_LOL_TOL = 6;
  localparam int FLD_ALIGN_CONFIG = 7;
  localparam int FLD_ALIGNED_FREQ = 8;
  localparam int FLD_BUILDOUT_SPEED = 9;
  localparam int FLD_DETECTOR_CAL = 10;
  localparam int FLD_MCLK_CAL = 11;
  localparam logic [7:0] FIELD_OFFSET [NUM_FIELDS] = '{
    8'h36, 8'h3a, 8'h3b, 8'h3d, 8'h3f, 8'h41, 8'h43, 8'h45, 8'h46, 8'h4c, 8'h4d, 8'h4f};
  localparam logic [7:0] FIELD_LAST [NUM_FIELDS] = '{
    8'h36, 8'h3a, 8'h3c, 8'h3e, 8'h40, 8'h42, 8'h44, 8'h45, 8'h4b, 8'h4c, 8'h4e, 8'h54};
  localparam int FIELD_BYTES [NUM_FIELDS] = '{1, 1, 2, 2, 2, 2, 2, 1, 6, 1, 2, 6};
  localparam logic [47:0] FIELD_RESET = 48'h0000_0000_0000;
  localparam logic [7:0] ALIGN_READ_MASK = 8'h0f;
  localparam logic [7:0] FIELD_READ_MASK = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FAST_BW_MSB = 5;
  localparam int DAMPING_LSB = 6;
  localparam int ALIGN_X_BIT = 0;
  localparam int ALIGN_Y_BIT = 1;
  localparam int SHIFT_RATE_LSB = 2;
  localparam int FREQ_N_WIDTH = 17;
  localparam int SPEED_INDEX_MSB = 5;
  localparam int SPEED_BAND_LSB = 6;
  localparam int SPEED_WIDTH = 18;
  localparam int MCLK_CAL_WIDTH = 28;
  localparam logic [7:0] FORCE_HOLDOVER_VALUE = 8'h01;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PLR_SHIFT_NORMAL = 2'h0,
    PLR_SHIFT_SLOWER = 2'h1,
    PLR_SHIFT_SLOWEST = 2'h2,
    PLR_SHIFT_FASTER = 2'h3
  } plr_shift_rate_type;
endpackage

// ==== plr_field.sv ====
// One byte-addressed register field with staged, coherent multi-byte commit
`timescale 1ns/1ps
module plr_field #(
  parameter int BYTES = 2,
  parameter logic [47:0] RESET = 48'h0000_0000_0000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Byte write
  input wire logic wr_in,
  input wire logic [2:0] idx_in,
  input wire logic [7:0] data_in,
  // Committed value
  output logic [8*BYTES-1:0] value_out
);
  logic [8*BYTES-1:0] stage;
  logic last_byte;
  logic [8*BYTES-1:0] next_value;

  assign last_byte = (idx_in == 3'(BYTES - 1));

  generate
    if (BYTES == 1) begin : g_single
      assign next_value = data_in;
    end else begin : g_multi
      assign next_value = {data_in, stage[8*(BYTES-1)-1:0]};
    end
  endgenerate

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage <= RESET[8*BYTES-1:0];
    end else if (wr_in) begin
      stage[8*idx_in +: 8] <= data_in;
    end
  end

  // Lower bytes wait in stage; the top byte commits the whole word
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_out <= RESET[8*BYTES-1:0];
    end else if (wr_in && last_byte) begin
      value_out <= next_value;
    end
  end
endmodule

// ==== pps_loop_runtime_regs.sv ====
// Run-time configuration and calibration registers of the pulse-disciplined loop
`timescale 1ns/1ps
module pps_loop_runtime_regs (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port from the serial interface
  input wire logic [7:0] addr_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  // Phase error samples from the detector
  input wire logic err_valid_in,
  input wire logic [15:0] phase_err_ns_in,
  // Raw reference phase readings
  input wire logic raw_valid_in,
  input wire logic [47:0] raw_phase_in,
  // Corrected phase readings
  output logic corrected_valid_out,
  output logic [47:0] corrected_phase_out,
  // Loop settings
  output logic force_holdover_out,
  output logic [5:0] fast_bw_index_out,
  output logic [1:0] damping_sel_out,
  output logic [15:0] target_bw_index_out,
  output logic target_below_fast_out,
  output logic align_x_out,
  output logic align_y_out,
  output plr_pkg::plr_shift_rate_type shift_rate_out,
  output logic [16:0] aligned_freq_n_out,
  output logic phase_align_needed_out,
  output logic [17:0] buildout_speed_out,
  output logic [27:0] mclk_correction_out,
  // Lock supervision
  output logic [15:0] bucket_count_out,
  output logic bucket_full_out,
  output logic lol_alarm_out,
  output logic reentry_ok_out,
  output logic resume_allowed_out
);
  // ----------------------------------------------------------------
  // Field storage and address decode
  // ----------------------------------------------------------------
  logic [47:0] value [plr_pkg::NUM_FIELDS];
  logic [plr_pkg::NUM_FIELDS-1:0] hit;
  logic [7:0] rd_part [plr_pkg::NUM_FIELDS];
  logic [7:0] rd_byte;

  genvar gi;
  generate
    for (gi = 0; gi < plr_pkg::NUM_FIELDS; gi++) begin : g_field
      localparam int NB = plr_pkg::FIELD_BYTES[gi];
      logic [2:0] idx;
      logic [8*NB-1:0] field_q;
      logic [7:0] mask;
      assign hit[gi] = (addr_in >= plr_pkg::FIELD_OFFSET[gi])
                    && (addr_in <= plr_pkg::FIELD_LAST[gi]);
      assign idx = 3'(addr_in - plr_pkg::FIELD_OFFSET[gi]);
      assign mask = (gi == plr_pkg::FLD_ALIGN_CONFIG) ? plr_pkg::ALIGN_READ_MASK
                                                      : plr_pkg::FIELD_READ_MASK;
      assign rd_part[gi] = hit[gi] ? (field_q[8*idx +: 8] & mask) : 8'h00;
      plr_field #(
        .BYTES(NB),
        .RESET(plr_pkg::FIELD_RESET)
      ) u_field (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_in(wr_en_in && hit[gi]),
        .idx_in(idx),
        .data_in(wr_data_in),
        .value_out(field_q)
      );
      if (NB == 6) begin : g_full
        assign value[gi] = field_q;
      end else begin : g_pad
        assign value[gi] = {{(48 - 8*NB){1'b0}}, field_q};
      end
    end
  endgenerate

  // Fields never overlap, so an OR of the per-field bytes is the mux
  always_comb begin
    rd_byte = plr_pkg::UNMAPPED_READ;
    for (int i = 0; i < plr_pkg::NUM_FIELDS; i++) begin
      rd_byte = rd_byte | rd_part[i];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_en_in) begin
      rd_data_out <= rd_byte;
    end
  end

  // ----------------------------------------------------------------
  // Settings decode
  // ----------------------------------------------------------------
  logic [7:0] loop_param;
  logic [7:0] align_cfg;
  logic [7:0] speed_cfg;
  logic [15:0] bucket_thr;
  logic [15:0] bucket_cap;
  logic [15:0] reentry_tol;
  logic [15:0] lol_tol;
  logic [15:0] detector_cal;
  logic next_force;
  logic [16:0] next_freq_n;
  logic [17:0] next_speed;

  assign loop_param = value[plr_pkg::FLD_LOOP_PARAM][7:0];
  assign align_cfg = value[plr_pkg::FLD_ALIGN_CONFIG][7:0];
  assign speed_cfg = value[plr_pkg::FLD_BUILDOUT_SPEED][7:0];
  assign bucket_thr = value[plr_pkg::FLD_BUCKET_THR][15:0];
  assign bucket_cap = value[plr_pkg::FLD_BUCKET_CAP][15:0];
  assign reentry_tol = value[plr_pkg::FLD_REENTRY_TOL][15:0];
  assign lol_tol = value[plr_pkg::FLD_LOL_TOL][15:0];
  assign detector_cal = value[plr_pkg::FLD_DETECTOR_CAL][15:0];
  // Other run-time control values are reserved and run normally
  assign next_force = value[plr_pkg::FLD_RUNTIME_CONTROL][7:0]
                   == plr_pkg::FORCE_HOLDOVER_VALUE;
  assign next_freq_n = value[plr_pkg::FLD_ALIGNED_FREQ][plr_pkg::FREQ_N_WIDTH-1:0];
  // index x 16^band: shift left by four bits per band step
  assign next_speed = 18'(speed_cfg[plr_pkg::SPEED_INDEX_MSB:0])
                   << {speed_cfg[7:plr_pkg::SPEED_BAND_LSB], 2'b00};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      force_holdover_out <= 1'b0;
      fast_bw_index_out <= 6'h00;
      damping_sel_out <= 2'h0;
      target_bw_index_out <= 16'h0000;
      target_below_fast_out <= 1'b0;
      align_x_out <= 1'b0;
      align_y_out <= 1'b0;
      shift_rate_out <= plr_pkg::PLR_SHIFT_NORMAL;
      aligned_freq_n_out <= 17'h00000;
      phase_align_needed_out <= 1'b0;
      buildout_speed_out <= 18'h00000;
      mclk_correction_out <= 28'h0000000;
    end else begin
      force_holdover_out <= next_force;
      fast_bw_index_out <= loop_param[plr_pkg::FAST_BW_MSB:0];
      damping_sel_out <= loop_param[7:plr_pkg::DAMPING_LSB];
      target_bw_index_out <= value[plr_pkg::FLD_TARGET_BW][15:0];
      // Misprogramming flag; the loop still relies on software ordering
      target_below_fast_out <= value[plr_pkg::FLD_TARGET_BW][15:0]
                            < 16'(loop_param[plr_pkg::FAST_BW_MSB:0]);
      align_x_out <= align_cfg[plr_pkg::ALIGN_X_BIT];
      align_y_out <= align_cfg[plr_pkg::ALIGN_Y_BIT];
      shift_rate_out <= plr_pkg::plr_shift_rate_type'(
        align_cfg[plr_pkg::SHIFT_RATE_LSB +: 2]);
      aligned_freq_n_out <= next_freq_n;
      phase_align_needed_out <= (next_freq_n != 17'h00000);
      buildout_speed_out <= next_speed;
      mclk_correction_out <= value[plr_pkg::FLD_MCLK_CAL][plr_pkg::MCLK_CAL_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Phase reading correction
  // ----------------------------------------------------------------
  logic [47:0] next_corrected;

  // Offset is sampled on the reading strobe; software keeps it still around it
  assign next_corrected = raw_phase_in + {{32{detector_cal[15]}}, detector_cal};

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      corrected_valid_out <= 1'b0;
      corrected_phase_out <= 48'h0000_0000_0000;
    end else begin
      corrected_valid_out <= raw_valid_in;
      if (raw_valid_in) begin
        corrected_phase_out <= next_corrected;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock supervision
  // ----------------------------------------------------------------
  logic err_over;
  logic [15:0] bucket_base;
  logic [15:0] next_bucket;

  assign err_over = phase_err_ns_in > bucket_thr;
  // Lowering the capacity clamps the count at the next sample
  assign bucket_base = (bucket_count_out > bucket_cap) ? bucket_cap : bucket_count_out;
  assign next_bucket = err_over ? ((bucket_base < bucket_cap) ? bucket_base + 16'h0001
                                                              : bucket_base)
                                : ((bucket_base != 16'h0000) ? bucket_base - 16'h0001
                                                             : 16'h0000);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bucket_count_out <= 16'h0000;
      bucket_full_out <= 1'b0;
      lol_alarm_out <= 1'b0;
      reentry_ok_out <= 1'b0;
    end else if (err_valid_in) begin
      bucket_count_out <= next_bucket;
      bucket_full_out <= (bucket_cap != 16'h0000) && (next_bucket == bucket_cap);
      lol_alarm_out <= phase_err_ns_in > lol_tol;
      reentry_ok_out <= phase_err_ns_in <= reentry_tol;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      resume_allowed_out <= 1'b0;
    end else begin
      resume_allowed_out <= reentry_ok_out && !force_holdover_out;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_lol_alarm_level: assert property (err_valid_in |=>
    lol_alarm_out == ($past(phase_err_ns_in) > $past(lol_tol)))
    else $error("loss-of-lock alarm does not match tolerance");
  a_reentry_ok_level: assert property (err_valid_in |=>
    reentry_ok_out == ($past(phase_err_ns_in) <= $past(reentry_tol)))
    else $error("re-entry flag does not match tolerance");
  a_resume_blocked: assert property (force_holdover_out |=> !resume_allowed_out)
    else $error("resume allowed during forced holdover");
  a_bucket_bound: assert property (err_valid_in |=>
    bucket_count_out <= $past(bucket_cap))
    else $error("bucket count above capacity");
  a_bucket_fill: assert property (err_valid_in && err_over
    && bucket_count_out < bucket_cap |=> bucket_count_out == $past(bucket_count_out) + 16'h0001)
    else $error("bucket did not count an over-threshold event");
  a_bucket_leak: assert property (err_valid_in && !err_over
    && bucket_count_out != 16'h0000 && bucket_count_out <= bucket_cap
    |=> bucket_count_out == $past(bucket_count_out) - 16'h0001)
    else $error("bucket did not leak");
  a_phase_corrected: assert property (raw_valid_in |=> corrected_valid_out
    && corrected_phase_out == $past(raw_phase_in) + {{32{$past(detector_cal[15])}},
                                                     $past(detector_cal)})
    else $error("phase reading not corrected by detector offset");
  a_holdover_force: assert property (force_holdover_out ==
    ($past(value[plr_pkg::FLD_RUNTIME_CONTROL][7:0]) == plr_pkg::FORCE_HOLDOVER_VALUE))
    else $error("holdover force does not follow control register");
  a_align_needed: assert property (##1 phase_align_needed_out ==
    ($past(value[plr_pkg::FLD_ALIGNED_FREQ][16:0]) != 17'h00000))
    else $error("alignment need does not follow frequency field");
  a_speed_scale: assert property (##1 buildout_speed_out ==
    (18'($past(speed_cfg[5:0])) << (4 * $past(speed_cfg[7:6]))))
    else $error("build-out speed scaling wrong");
  a_align_bits: assert property (##1 align_x_out == $past(align_cfg[0])
    && align_y_out == $past(align_cfg[1]) && shift_rate_out == $past(align_cfg[3:2]))
    else $error("alignment config outputs wrong");
  a_coherent_freq: assert property (wr_en_in && hit[plr_pkg::FLD_ALIGNED_FREQ]
    && addr_in != plr_pkg::FIELD_LAST[plr_pkg::FLD_ALIGNED_FREQ]
    |=> $stable(value[plr_pkg::FLD_ALIGNED_FREQ]))
    else $error("partial write changed aligned frequency");

  // Settings outputs trail their committed field by one cycle
  a_target_index: assert property (##1 target_bw_index_out ==
    $past(value[plr_pkg::FLD_TARGET_BW][15:0]))
    else $error("target bandwidth index does not follow its field");
  a_loop_param: assert property (##1 fast_bw_index_out == $past(loop_param[5:0])
    && damping_sel_out == $past(loop_param[7:6]))
    else $error("loop parameter outputs wrong");
  a_freq_field: assert property (##1 aligned_freq_n_out ==
    $past(value[plr_pkg::FLD_ALIGNED_FREQ][16:0]))
    else $error("aligned frequency count does not follow its field");
  a_mclk_field: assert property (##1 mclk_correction_out ==
    $past(value[plr_pkg::FLD_MCLK_CAL][27:0]))
    else $error("master clock correction does not follow its field");

  // A lower byte alone must leave the committed index untouched
  a_coherent_target: assert property (wr_en_in && hit[plr_pkg::FLD_TARGET_BW]
    && addr_in != plr_pkg::FIELD_LAST[plr_pkg::FLD_TARGET_BW]
    |=> $stable(value[plr_pkg::FLD_TARGET_BW]))
    else $error("partial write changed target bandwidth index");

  // Alarm, re-entry flag, bucket state and corrected readings move only on their strobes
  a_supervision_hold: assert property (!err_valid_in |=> $stable(lol_alarm_out)
    && $stable(reentry_ok_out) && $stable(bucket_count_out))
    else $error("supervision changed without a phase error sample");
  a_corrected_idle: assert property (!raw_valid_in |=> !corrected_valid_out
    && $stable(corrected_phase_out))
    else $error("corrected reading changed without a raw reading");
  a_bucket_full: assert property (err_valid_in |=> bucket_full_out ==
    ($past(bucket_cap) != 16'h0000 && bucket_count_out == $past(bucket_cap)))
    else $error("bucket full flag wrong");

  // Reserved config bits are stored but read back as zero
  a_config_readback: assert property (rd_en_in
    && addr_in == plr_pkg::FIELD_OFFSET[plr_pkg::FLD_ALIGN_CONFIG]
    |=> rd_data_out == ($past(align_cfg) & plr_pkg::ALIGN_READ_MASK))
    else $error("align config readback wrong");

  c_lol_raised: cover property (err_valid_in && phase_err_ns_in > lol_tol ##1 lol_alarm_out);
  c_bucket_full: cover property (bucket_full_out && bucket_cap > 16'h0002);
  c_freq_commit: cover property (wr_en_in && addr_in == plr_pkg::FIELD_LAST[8]
    ##1 phase_align_needed_out == 1'b0 ##1 phase_align_needed_out);
  c_forced_holdover: cover property (force_holdover_out && reentry_ok_out);
  c_partial_target: cover property (wr_en_in
    && addr_in == plr_pkg::FIELD_OFFSET[plr_pkg::FLD_TARGET_BW] ##1 !wr_en_in);
endmodule

// ==== plr_host.sv ====
// Host model driving the byte register port of the loop registers
`timescale 1ns/1ps
module plr_host (
  // Clock
  input wire logic clk_in,
  // Register port
  output logic [7:0] addr_out,
  output logic wr_en_out,
  output logic [7:0] wr_data_out,
  output logic rd_en_out,
  input wire logic [7:0] rd_data_in
);
  initial begin
    addr_out = 8'h00;
    wr_en_out = 1'b0;
    wr_data_out = 8'h00;
    rd_en_out = 1'b0;
  end
  // Lowest byte first, so the field commits only with its top byte
  task automatic write_field(input logic [7:0] a, input int n, input logic [47:0] v);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      addr_out <= a + 8'(i);
      wr_data_out <= v[8*i +: 8];
      wr_en_out <= 1'b1;
    end
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // Released data must not keep showing the last byte
    wr_data_out <= ~wr_data_out;
  endtask
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1;
    d = rd_data_in;
  endtask
endmodule

// ==== tb_pps_loop_runtime_regs.sv ====
// Self-checking bench for the loop run-time registers
`timescale 1ns/1ps
module tb_pps_loop_runtime_regs;
  logic clk_in, rst_in, wr_en, rd_en, err_valid, raw_valid, corr_valid;
  logic force_ho, tgt_below, ax, ay, need, full, loss_of_lock, reok, resume;
  logic [7:0] addr, wr_data, rd_data;
  logic [15:0] phase_err, tgt, bcount;
  logic [47:0] raw_phase, corr_phase, v;
  logic [5:0] fast_bw;
  logic [1:0] damp;
  plr_pkg::plr_shift_rate_type shift;
  logic [16:0] freq_n;
  logic [17:0] speed;
  logic [27:0] mclk;
  logic [7:0] mdl [int];
  int bad_count, compares, cnt;

  plr_host i_host (.clk_in(clk_in), .addr_out(addr), .wr_en_out(wr_en),
    .wr_data_out(wr_data), .rd_en_out(rd_en), .rd_data_in(rd_data));
  pps_loop_runtime_regs i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wr_en_in(wr_en), .wr_data_in(wr_data), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .err_valid_in(err_valid), .phase_err_ns_in(phase_err), .raw_valid_in(raw_valid),
    .raw_phase_in(raw_phase), .corrected_valid_out(corr_valid),
    .corrected_phase_out(corr_phase), .force_holdover_out(force_ho),
    .fast_bw_index_out(fast_bw), .damping_sel_out(damp), .target_bw_index_out(tgt),
    .target_below_fast_out(tgt_below), .align_x_out(ax), .align_y_out(ay),
    .shift_rate_out(shift), .aligned_freq_n_out(freq_n), .phase_align_needed_out(need),
    .buildout_speed_out(speed), .mclk_correction_out(mclk), .bucket_count_out(bcount),
    .bucket_full_out(full), .lol_alarm_out(loss_of_lock), .reentry_ok_out(reok),
    .resume_allowed_out(resume));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [47:0] fld(input int a, input int n);
    logic [47:0] r;
    r = 48'h0;
    for (int i = 0; i < n; i++) begin
      if (mdl.exists(a + i)) r[8*i +: 8] = mdl[a + i];
    end
    return r;
  endfunction

  task automatic wr(input int a, input int n, input logic [47:0] d);
    for (int i = 0; i < n; i++) mdl[a + i] = d[8*i +: 8];
    i_host.write_field(8'(a), n, d);
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic chk_map();
    logic [7:0] d;
    logic [7:0] e;
    for (int a = 'h34; a < 'h58; a++) begin
      i_host.read_byte(8'(a), d);
      e = mdl.exists(a) ? mdl[a] : 8'h00;
      if (a == 'h45) e = e & 8'h0f;
      chk_rd(d, e);
    end
  endtask

  task automatic chk_settings();
    logic [47:0] sp;
    sp = fld('h4c, 1);
    chk_out(force_ho, fld('h36, 1) == 48'h1);
    chk_out(fast_bw, fld('h3a, 1) & 48'h3f);
    chk_out(damp, fld('h3a, 1) >> 6);
    chk_out(tgt, fld('h3b, 2));
    chk_out(tgt_below, fld('h3b, 2) < (fld('h3a, 1) & 48'h3f));
    chk_out(ax, fld('h45, 1) & 48'h1);
    chk_out(ay, (fld('h45, 1) >> 1) & 48'h1);
    chk_out(shift, (fld('h45, 1) >> 2) & 48'h3);
    chk_out(freq_n, fld('h46, 6) & 48'h1ffff);
    chk_out(need, (fld('h46, 6) & 48'h1ffff) != 48'h0);
    chk_out(speed, (sp & 48'h3f) << (4 * sp[7:6]));
    chk_out(mclk, fld('h4f, 6) & 48'hfffffff);
  endtask

  task automatic send_err(input logic [15:0] e);
    int thr;
    int cap;
    thr = int'(fld('h3d, 2));
    cap = int'(fld('h3f, 2));
    if (cnt > cap) cnt = cap;
    if (e > thr) cnt = (cnt < cap) ? cnt + 1 : cap;
    else cnt = (cnt > 0) ? cnt - 1 : 0;
    @(posedge clk_in);
    err_valid <= 1'b1;
    phase_err <= e;
    @(posedge clk_in);
    err_valid <= 1'b0;
    phase_err <= ~e;
    #1;
    chk_out(bcount, 48'(cnt));
    chk_out(full, cnt == cap && cap != 0);
    chk_out(loss_of_lock, e > fld('h43, 2));
    chk_out(reok, e <= fld('h41, 2));
    @(posedge clk_in);
    #1;
    chk_out(resume, e <= fld('h41, 2) && fld('h36, 1) != 48'h1);
    chk_out(loss_of_lock, e > fld('h43, 2));
  endtask

  task automatic raw_burst(input logic [15:0] cal);
    logic [47:0] r;
    logic [47:0] prev;
    logic [47:0] ofs;
    ofs = {{32{cal[15]}}, cal};
    wr('h4d, 2, cal);
    // Offset settles well ahead of the first reading
    repeat (20) @(posedge clk_in);
    for (int i = 0; i < 5; i++) begin
      r = 48'({$urandom(), $urandom()});
      @(posedge clk_in);
      raw_valid <= 1'b1;
      raw_phase <= r;
      if (i > 0) begin
        #1;
        chk_out(corr_valid, 48'h1);
        chk_out(corr_phase, prev + ofs);
      end
      prev = r;
    end
    @(posedge clk_in);
    raw_valid <= 1'b0;
    raw_phase <= ~prev;
    #1;
    chk_out(corr_phase, prev + ofs);
    @(posedge clk_in);
    #1;
    chk_out(corr_valid, 48'h0);
    chk_out(corr_phase, prev + ofs);
    // Offset held long after the last reading
    repeat (1000) @(posedge clk_in);
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst_in = 1'b1;
    err_valid = 1'b0;
    phase_err = 16'h0000;
    raw_valid = 1'b0;
    raw_phase = 48'h0;
    bad_count = 0;
    compares = 0;
    cnt = 0;
    void'($urandom(62855));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    chk_map();
    chk_settings();
    for (int f = 0; f < plr_pkg::NUM_FIELDS; f++) begin
      v = 48'({$urandom(), $urandom()});
      if (f == plr_pkg::FLD_ALIGNED_FREQ) v = v & 48'h1ffff;
      if (f == plr_pkg::FLD_TARGET_BW) v = v | 48'h40;
      wr(plr_pkg::FIELD_OFFSET[f], plr_pkg::FIELD_BYTES[f], v);
    end
    chk_map();
    chk_settings();
    for (int k = 0; k < 4; k++) begin
      wr('h36, 1, 48'(k));
      wr('h45, 1, (48'($urandom()) & 48'hf3) | 48'(k << 2));
      wr('h4c, 1, 48'(k << 6) | (48'($urandom()) & 48'h3f));
      wr('h46, 6, (k == 0) ? 48'h0 : (48'($urandom()) & 48'h1ffff) | 48'h1);
      chk_settings();
    end
    // Lower byte alone must not reach the output
    v = fld('h3b, 2);
    i_host.write_field(8'h3b, 1, 48'h5a);
    repeat (3) @(posedge clk_in);
    #1;
    chk_out(tgt, v);
    chk_map();
    mdl['h3b] = 8'h5a;
    wr('h3c, 1, 48'ha5);
    chk_settings();
    wr('h3d, 2, 48'd100);
    wr('h3f, 2, 48'd3);
    wr('h41, 2, 48'd50);
    wr('h43, 2, 48'd200);
    wr('h36, 1, 48'h0);
    for (int i = 0; i < 5; i++) send_err(16'd150);
    for (int i = 0; i < 20; i++) begin
      if (i == 10) wr('h36, 1, 48'h1);
      send_err(16'($urandom_range(300)));
    end
    for (int i = 0; i < 3; i++) send_err(16'd150);
    wr('h3f, 2, 48'd1);
    send_err(16'd20);
    raw_burst(16'hfffe);
    raw_burst(16'($urandom()));
    end_of_test();
  end
endmodule
